// ==== dv/pio_board.sv ====
`timescale 1ns/10ps
module pio_board (
    input  wire logic        mclk_i,
    input  wire logic [63:0] pin_out_o,
    input  wire logic [63:0] pin_oe_o,
    input  wire logic [63:0] pin_pullup_o,
    output wire logic [63:0] pin_lvl_o
);
    // a pin nobody drives or pulls floats: its level flips every cycle
    logic [63:0] flt = 64'h0;
    always @(posedge mclk_i) flt <= ~flt;
    assign pin_lvl_o = pin_oe_o & pin_out_o | ~pin_oe_o & (pin_pullup_o | flt);
endmodule

// ==== dv/pio_props.sv ====
`timescale 1ns/10ps
module pio_props (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        rto_timer_trig_i,
    input wire logic        rto_ext_trig_i,
    input wire logic [63:0] pin_out_o,
    input wire logic [63:0] pin_oe_o,
    input wire logic [63:0] pin_pullup_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // shadows of accepted writes, since the design's registers are out of sight
    logic [7:0] dir0, ctl, rbuf;
    wire        wr_ok = avs_write_i && !avs_waitrequest_o;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir0 <= 8'h00;
            ctl  <= 8'h00;
            rbuf <= 8'h00;
        end else if (wr_ok) begin
            if (avs_address_i == 5'h08) dir0 <= avs_writedata_i[7:0];
            if (avs_address_i == 5'h1B) ctl <= avs_writedata_i[7:0];
            if (avs_address_i == 5'h1C) rbuf <= avs_writedata_i[7:0];
        end
    end
    sequence lo_tmr;
        $rose(rto_timer_trig_i) && ctl[0] && !ctl[2];
    endsequence
    sequence hi_ext;
        $rose(rto_ext_trig_i) && ctl[1] && ctl[3];
    endsequence
    chk_reset_idle: assert property (
        $rose(rst_n_i) |-> (pin_out_o | pin_oe_o | pin_pullup_o) == 64'h0)
        else $error("pins not idle after reset");
    chk_dir_write: assert property (
        wr_ok && avs_address_i == 5'h08 |=> ##[0:1] pin_oe_o[7:0] == dir0)
        else $error("port zero direction not applied");
    chk_p2_no_drive: assert property (pin_oe_o[23:16] == 8'h00)
        else $error("input port driven");
    chk_p2_pull_grp: assert property (pin_pullup_o[17:16] == 2'b00 &&
        (pin_pullup_o[23:18] == 6'h00 || pin_pullup_o[23:18] == 6'h3F))
        else $error("input port pull-ups not grouped");
    chk_p7_no_pull: assert property (pin_pullup_o[63:56] == 8'h00)
        else $error("port seven pulled up");
    chk_pull_on_in: assert property ((pin_pullup_o & pin_oe_o) == 64'h0)
        else $error("pull-up on an output pin");
    chk_rto_lo: assert property (lo_tmr |=> pin_out_o[3:0] == rbuf[3:0])
        else $error("lower nibble not loaded");
    chk_rto_hi: assert property (hi_ext |=> pin_out_o[7:4] == rbuf[7:4])
        else $error("upper nibble not loaded");
endmodule

// ==== dv/tb_parallel_io_ports_pullup.sv ====
`timescale 1ns/10ps
module tb_parallel_io_ports_pullup;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0;
    logic        rd = 1'b0, wr = 1'b0, ttrg = 1'b0, etrg = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, q;
    logic [7:0]  dir [8];
    logic [7:0]  ctab [4] = '{8'h03, 8'h0F, 8'h01, 8'h0B};
    logic [7:0]  b, old, d1;
    wire  [31:0] rdat;
    wire         wq;
    wire  [63:0] pin_in, pout, poe, ppu;
    int          n_mismatch = 0, checked = 0;
    pio_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .rto_timer_trig_i(ttrg), .rto_ext_trig_i(etrg),
        .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe), .pin_pullup_o(ppu));
    pio_board u_board (.mclk_i(mclk_i), .pin_out_o(pout), .pin_oe_o(poe),
        .pin_pullup_o(ppu), .pin_lvl_o(pin_in));
    initial forever #25 mclk_i = ~mclk_i;
    function automatic logic [7:0] exp_pull(input int n, input logic [7:0] d);
        return (n == 7) ? 8'h00 : (n == 2) ? 8'hFC : ~d;
    endfunction
    function automatic logic [7:0] exp_rto(input logic [7:0] c, input logic [7:0] bf,
                                           input logic [7:0] o, input logic ext);
        logic lo, hi;
        lo = c[0] && (c[2] == ext);
        hi = c[1] && (c[3] == ext);
        return {hi ? bf[7:4] : o[7:4], lo ? bf[3:0] : o[3:0]};
    endfunction
    task automatic chk(input logic [63:0] s, input logic [63:0] e, input string nm);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        adr  <= a;
        wdat <= {24'h0, d};
        rd   <= !w;
        wr   <= w;
        do @(posedge mclk_i); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        void'($urandom(34));
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(pout | poe | ppu, 64'h0, "reset pins");
        acc(1'b0, 5'h09, 8'h00);
        chk(q, 32'h0, "dir reset");
        acc(1'b0, 5'h1B, 8'h00);
        chk(q, 32'h0, "rto ctl reset");
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            dir[n] = (n == 0) ? 8'hA5 : 8'($urandom);
            acc(1'b1, 5'h08 + 5'(n), dir[n]);
            acc(1'b1, 5'h10 + 5'(n), 8'hFF);
        end
        acc(1'b1, 5'h1A, 8'h01);
        acc(1'b1, 5'h1D, 8'hFF);
        settle();
        for (int n = 0; n < 8; n++) begin
            chk(poe[8*n+:8], (n == 2) ? 8'h00 : dir[n], "direction");
            chk(ppu[8*n+:8], exp_pull(n, dir[n]), "pull-up");
        end
        acc(1'b1, 5'h1A, 8'h00);
        settle();
        chk(ppu[23:16], 8'h00, "input port pull off");
        acc(1'b0, 5'h08, 8'h00);
        chk(q, {24'h0, dir[0]}, "dir readback");
        acc(1'b0, 5'h0A, 8'h00);
        chk(q, 32'h0, "input port dir readback");
        acc(1'b0, 5'h11, 8'h00);
        chk(q, {24'h0, ~dir[1]}, "pull readback");
        acc(1'b0, 5'h17, 8'h00);
        chk(q, 32'h0, "port seven pull readback");
        d1 = 8'($urandom);
        acc(1'b1, 5'h01, d1);
        settle();
        chk(pout[15:8], d1, "data latch");
        repeat (6) @(posedge mclk_i);
        acc(1'b0, 5'h19, 8'h00);
        chk(q, {24'h0, dir[1] & d1 | ~dir[1]}, "port one pin level");
        acc(1'b0, 5'h18, 8'h00);
        chk(q, {24'h0, ~dir[0]}, "port zero pin level");
        $display("test direction and pull-up done");
        for (int m = 0; m < 4; m++) begin
            b = 8'($urandom);
            old = pout[7:0];
            acc(1'b1, 5'h1C, b);
            acc(1'b1, 5'h1B, ctab[m]);
            @(posedge mclk_i);
            if (m[0]) etrg <= 1'b1;
            else ttrg <= 1'b1;
            @(posedge mclk_i);
            ttrg <= 1'b0;
            etrg <= 1'b0;
            settle();
            chk(pout[7:0], exp_rto(ctab[m], b, old, m[0]), "rto nibbles");
        end
        acc(1'b0, 5'h1C, 8'h00);
        chk(q, {24'h0, b}, "rto buffer readback");
        $display("test real-time output done");
        wrap_up();
    end
endmodule
bind pio_top pio_props u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .rto_timer_trig_i(rto_timer_trig_i), .rto_ext_trig_i(rto_ext_trig_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o));

// ==== hw/pio_defs.vh ====
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH
// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define PIO_ADDR_W       5
`define PIO_OFS_DATA     5'h00
`define PIO_OFS_DIR      5'h08
`define PIO_OFS_PULL     5'h10
`define PIO_OFS_PIN      5'h18
`define PIO_OFS_P2PULL   5'h1A
`define PIO_OFS_RTOCTL   5'h1B
`define PIO_OFS_RTOBUF   5'h1C
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PIO_RTO_LO_EN    0
`define PIO_RTO_HI_EN    1
`define PIO_RTO_LO_SRC   2
`define PIO_RTO_HI_SRC   3
`define PIO_RST_BYTE     8'h00
`define PIO_RST_BIT      1'b0
`define PIO_P2_PULL_MASK 8'hFC
`define PIO_NO_PULL      8'h00
`define PIO_PORT_IN      2
`define PIO_PORT_NOPULL  7
`define PIO_NPORTS       8
`define PIO_RST_CTL      4'h0
`define PIO_WAIT_IDLE    1'b1
`endif

// ==== hw/pio_sync.v ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ----------------------------------------------------------------
module pio_sync #(
    parameter W = 8
) (
    input  wire         mclk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1  <= {W{1'b0}};
            s2  <= {W{1'b0}};
            s3  <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            s1  <= d_i;
            s2  <= s1;
            s3  <= s2;
            q_o <= (s2 & s3) | (q_o & (s2 | s3));
        end
    end
endmodule

// ==== hw/pio_top.v ====
`timescale 1ns/10ps
`include "pio_defs.vh"
module pio_top (
    input  wire        mclk_i,
    input  wire        rst_n_i,
    input  wire [4:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire        rto_timer_trig_i,
    input  wire        rto_ext_trig_i,
    input  wire [63:0] pin_in_i,
    output reg  [63:0] pin_out_o,
    output reg  [63:0] pin_oe_o,
    output reg  [63:0] pin_pullup_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [63:0] out_latch;
    reg  [63:0] dir_out;
    reg  [55:0] pull_en;
    reg         p2_pull;
    reg  [3:0]  rto_ctl;
    reg  [7:0]  rto_buf;
    reg         ack;
    reg         trig_t_d;
    reg         trig_e_d;
    wire [63:0] pin_sync;
    wire [63:0] dir_eff;
    wire [63:0] pull_eff;
    wire        trig_t_rise;
    wire        trig_e_rise;
    wire        lo_fire;
    wire        hi_fire;
    reg  [31:0] next_rdata;
    reg  [63:0] next_out;
    integer     k;
    integer     j;

    pio_sync #(.W(64)) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pin_in_i),
        .q_o     (pin_sync)
    );

    // port two never drives
    assign dir_eff = dir_out & ~({56'h0, 8'hFF} << (8 * `PIO_PORT_IN));

    // pull-up only on inputs; port seven has none
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pull
            if (g == `PIO_PORT_IN) begin : g_p2
                assign pull_eff[8*g+7:8*g] = p2_pull ? `PIO_P2_PULL_MASK : `PIO_NO_PULL;
            end else if (g == `PIO_PORT_NOPULL) begin : g_p7
                assign pull_eff[8*g+7:8*g] = `PIO_NO_PULL;
            end else begin : g_pn
                assign pull_eff[8*g+7:8*g] = pull_en[8*g+7:8*g] & ~dir_out[8*g+7:8*g];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // real-time output triggers
    // ----------------------------------------------------------------
    // triggers come from same-clock logic, so only an edge detect is used
    assign trig_t_rise = rto_timer_trig_i & ~trig_t_d;
    assign trig_e_rise = rto_ext_trig_i & ~trig_e_d;
    assign lo_fire = rto_ctl[`PIO_RTO_LO_EN] &
                     (rto_ctl[`PIO_RTO_LO_SRC] ? trig_e_rise : trig_t_rise);
    assign hi_fire = rto_ctl[`PIO_RTO_HI_EN] &
                     (rto_ctl[`PIO_RTO_HI_SRC] ? trig_e_rise : trig_t_rise);

    function [7:0] pick;
        input [63:0] v;
        input [2:0]  n;
        begin
            pick = v[8*n +: 8];
        end
    endfunction

    wire wr_hit = avs_write_i & ack;
    wire rd_req = avs_read_i & ~ack;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            `PIO_OFS_P2PULL: next_rdata = {31'h0, p2_pull};
            `PIO_OFS_RTOCTL: next_rdata = {28'h0, rto_ctl};
            `PIO_OFS_RTOBUF: next_rdata = {24'h0, rto_buf};
            default: begin
                if (avs_address_i < `PIO_OFS_DIR)
                    next_rdata = {24'h0, pick(out_latch, avs_address_i[2:0])};
                else if (avs_address_i < `PIO_OFS_PULL)
                    next_rdata = {24'h0, pick(dir_eff, avs_address_i[2:0])};
                else if (avs_address_i < `PIO_OFS_PIN)
                    next_rdata = {24'h0, pick(pull_eff, avs_address_i[2:0])};
                else
                    next_rdata = {24'h0, pick(pin_sync, avs_address_i[2:0])};
            end
        endcase
    end

    always @* begin
        next_out = out_latch;
        if (wr_hit && avs_address_i < `PIO_OFS_DIR)
            next_out[8*avs_address_i[2:0] +: 8] = avs_writedata_i[7:0];
        // a trigger in the same cycle as a software write wins the nibble
        if (lo_fire)
            next_out[3:0] = rto_buf[3:0];
        if (hi_fire)
            next_out[7:4] = rto_buf[7:4];
    end

    // ----------------------------------------------------------------
    // Avalon slave handshake, one wait cycle per access
    // ----------------------------------------------------------------
    // ack marks the second cycle of an access, so a held request is served again every second cycle
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack               <= `PIO_RST_BIT;
            avs_waitrequest_o <= `PIO_WAIT_IDLE;
        end else begin
            ack               <= (avs_read_i | avs_write_i) & ~ack;
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack);
        end
    end

    // read data are caught when the access is first seen and stand until the next read
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= {4{`PIO_RST_BYTE}};
        end else if (rd_req) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // trigger edge memory
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_t_d <= `PIO_RST_BIT;
            trig_e_d <= `PIO_RST_BIT;
        end else begin
            trig_t_d <= rto_timer_trig_i;
            trig_e_d <= rto_ext_trig_i;
        end
    end

    // ----------------------------------------------------------------
    // port data latches and direction
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_latch <= {8{`PIO_RST_BYTE}};
        end else begin
            out_latch <= next_out;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_out <= {8{`PIO_RST_BYTE}};
        end else if (wr_hit && avs_address_i >= `PIO_OFS_DIR &&
                     avs_address_i < `PIO_OFS_PULL) begin
            for (k = 0; k < `PIO_NPORTS; k = k + 1) begin
                if (k == avs_address_i[2:0]) begin
                    dir_out[8*k +: 8] <= avs_writedata_i[7:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pull-up enables
    // ----------------------------------------------------------------
    // port seven has no enable register at all, so its writes fall away here
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pull_en <= {7{`PIO_RST_BYTE}};
        end else if (wr_hit && avs_address_i >= `PIO_OFS_PULL &&
                     avs_address_i < `PIO_OFS_PIN &&
                     avs_address_i[2:0] != `PIO_PORT_NOPULL) begin
            for (j = 0; j < `PIO_PORT_NOPULL; j = j + 1) begin
                if (j == avs_address_i[2:0]) begin
                    pull_en[8*j +: 8] <= avs_writedata_i[7:0];
                end
            end
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p2_pull <= `PIO_RST_BIT;
        end else if (wr_hit && avs_address_i == `PIO_OFS_P2PULL) begin
            p2_pull <= avs_writedata_i[0];
        end
    end

    // ----------------------------------------------------------------
    // real-time output control and buffer
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rto_ctl <= `PIO_RST_CTL;
            rto_buf <= `PIO_RST_BYTE;
        end else if (wr_hit) begin
            if (avs_address_i == `PIO_OFS_RTOCTL) begin
                rto_ctl <= avs_writedata_i[3:0];
            end
            if (avs_address_i == `PIO_OFS_RTOBUF) begin
                rto_buf <= avs_writedata_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // pin outputs, all registered
    // ----------------------------------------------------------------
    // next_out feeds both latch and pin, so a trigger reaches the pin without extra delay
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_out_o    <= {8{`PIO_RST_BYTE}};
            pin_oe_o     <= {8{`PIO_RST_BYTE}};
            pin_pullup_o <= {8{`PIO_RST_BYTE}};
        end else begin
            pin_out_o    <= next_out;
            pin_oe_o     <= dir_eff;
            pin_pullup_o <= pull_eff;
        end
    end
endmodule
